// [gpp_map.svh]
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH

// ****************************************
// Port layout
// ****************************************
`define GPP_WIDTH 8
`define GPP_ADDR_HI 9
`define GPP_ADDR_LO 2
`define GPP_ALL_ONES 8'hFF
`define GPP_ALL_ZERO 8'h00

// ****************************************
// Port identities and debug pins
// ****************************************
`define GPP_PORT_B 3'h1
`define GPP_PORT_C 3'h2
`define GPP_DBG_PORT_B 8'h80
`define GPP_DBG_PORT_C 8'h0F
`define GPP_TRIG_PIN 4

// ****************************************
// Reset values
// ****************************************
`define GPP_RST_ZERO 8'h00
`define GPP_RST_DRIVE2 8'hFF

// ****************************************
// Lock key and identification bytes
// ****************************************
// Arbitrary values, not tied to any product
`define GPP_LOCK_KEY 32'h5A5A_C3C3
`define GPP_ID_COUNT 4'hC
`define GPP_ID_TABLE {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, \
    8'h77, 8'h88, 8'h99, 8'hAA, 8'hBB, 8'hCC}

`endif

// [gpp_pkg.sv]
package gpp_pkg;

    // Byte wide per-pin vector
    typedef logic [7:0] gpp_byte_t;

    // Selects the configuration register on a write
    typedef enum logic [3:0] {
        GPP_SEL_DIR = 4'h0,
        GPP_SEL_IS = 4'h1,
        GPP_SEL_IBE = 4'h2,
        GPP_SEL_IEV = 4'h3,
        GPP_SEL_IM = 4'h4,
        GPP_SEL_AFSEL = 4'h5,
        GPP_SEL_DR2 = 4'h6,
        GPP_SEL_DR4 = 4'h7,
        GPP_SEL_DR8 = 4'h8,
        GPP_SEL_ODR = 4'h9,
        GPP_SEL_PUR = 4'hA,
        GPP_SEL_PDR = 4'hB,
        GPP_SEL_DEN = 4'hC,
        GPP_SEL_SLR = 4'hD,
        GPP_SEL_CR = 4'hE
    } gpp_cfg_sel_e;

endpackage

// [gpp_sync.sv]
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Two-stage synchroniser
// ****************************************
module gpp_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // First stage feeds only the second
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule

`default_nettype wire

// [gpp_irq_pin.sv]
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// One pin of interrupt detection
// ****************************************
module gpp_irq_pin (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Level and controls
    input wire logic i_level,
    input wire logic i_sense,
    input wire logic i_both,
    input wire logic i_polarity,
    input wire logic i_clear,
    // Raw status
    output logic o_raw
);

    logic prev_r;
    logic raw_r;
    logic rise;
    logic fall;
    logic hit;

    // Previous level for edge detection
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= i_level;
        end
    end

    // Edge selection: both edges or the chosen one
    assign rise = i_level & ~prev_r;
    assign fall = ~i_level & prev_r;
    assign hit = i_both ? (rise | fall) : (i_polarity ? rise : fall);

    // Level mode follows the input; edge mode is sticky, set beats clear
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            raw_r <= 1'b0;
        end else if (i_sense) begin
            raw_r <= (i_level == i_polarity);
        end else begin
            raw_r <= hit | (raw_r & ~i_clear);
        end
    end

    assign o_raw = raw_r;

endmodule

`default_nettype wire

// [gpp_port.sv]
`timescale 1ns/10ps
`default_nettype none
`include "gpp_map.svh"

module gpp_port
    import gpp_pkg::*;
#(
    parameter logic [2:0] PORT_INDEX = 3'h0,
    parameter logic [7:0] PIN_PRESENT = `GPP_ALL_ONES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Data register access
    input wire logic i_data_wr,
    input wire logic i_data_rd,
    input wire logic [`GPP_ADDR_HI:`GPP_ADDR_LO] i_data_addr,
    input wire gpp_byte_t i_data_wdata,
    output gpp_byte_t o_data_rdata,
    // Configuration writes
    input wire logic i_cfg_wr,
    input wire gpp_cfg_sel_e i_cfg_sel,
    input wire gpp_byte_t i_cfg_wdata,
    // Interrupt clear
    input wire logic i_irq_clear_wr,
    input wire gpp_byte_t i_irq_clear_data,
    // Lock
    input wire logic i_lock_wr,
    input wire logic [31:0] i_lock_wdata,
    output logic o_locked,
    // Identification
    input wire logic [3:0] i_id_sel,
    output gpp_byte_t o_id_value,
    // Pins
    input wire gpp_byte_t i_pin_in,
    output gpp_byte_t o_pin_out,
    output gpp_byte_t o_pin_oe,
    // Alternate function
    input wire gpp_byte_t i_alt_out,
    input wire gpp_byte_t i_alt_oe,
    output gpp_byte_t o_alt_in,
    // Configuration state
    output gpp_byte_t o_pin_direction_reg,
    output gpp_byte_t o_irq_sense_select,
    output gpp_byte_t o_irq_both_edge_select,
    output gpp_byte_t o_irq_event_polarity,
    output gpp_byte_t o_irq_mask_reg,
    output gpp_byte_t o_alt_function_select,
    output gpp_byte_t o_drive_two_ma_select,
    output gpp_byte_t o_drive_four_ma_select,
    output gpp_byte_t o_drive_eight_ma_select,
    output gpp_byte_t o_slew_select,
    output gpp_byte_t o_open_drain_select,
    output gpp_byte_t o_pullup_select,
    output gpp_byte_t o_pulldown_select,
    output gpp_byte_t o_digital_input_enable,
    output gpp_byte_t o_commit_permit_reg,
    // Status and events
    output gpp_byte_t o_pin_value_reg,
    output gpp_byte_t o_irq_raw_status,
    output gpp_byte_t o_irq_masked_status,
    output logic o_irq,
    output logic o_conv_trigger
);

    // ****************************************
    // Port-specific defaults
    // ****************************************
    localparam gpp_byte_t DBG_PINS = (PORT_INDEX == `GPP_PORT_B) ?
        `GPP_DBG_PORT_B : ((PORT_INDEX == `GPP_PORT_C) ?
        `GPP_DBG_PORT_C : `GPP_ALL_ZERO);
    localparam gpp_byte_t DBG_RST = DBG_PINS & PIN_PRESENT;
    localparam logic IS_PORT_B = (PORT_INDEX == `GPP_PORT_B);
    localparam logic [95:0] ID_TABLE = `GPP_ID_TABLE;

    gpp_byte_t dir_r, is_r, ibe_r, iev_r, im_r, afsel_r;
    gpp_byte_t dr2_r, dr4_r, dr8_r, slr_r, odr_r;
    gpp_byte_t pur_r, pdr_r, den_r, cr_r, data_r, rdata_r, id_r;
    gpp_byte_t pin_sync, pin_in_en, raw, masked, cfg_val;
    gpp_byte_t af_en, data_wm, data_nxt, drv_val, drv_en;
    logic unlocked_r, trig_r, raw_trig_d_r;

    // ****************************************
    // Input synchroniser and digital enable
    // ****************************************
    gpp_sync #(.WIDTH(`GPP_WIDTH)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async(i_pin_in),
        .o_sync(pin_sync)
    );

    assign pin_in_en = pin_sync & den_r & PIN_PRESENT;

    // ****************************************
    // Configuration registers
    // ****************************************
    // Only pads that exist take a write
    assign cfg_val = i_cfg_wdata & PIN_PRESENT;
    // Protected bits need unlock plus commit
    assign af_en = PIN_PRESENT & (~DBG_PINS | (cr_r & {8{unlocked_r}}));

    // Register writes, reset values per port
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            dir_r <= `GPP_RST_ZERO;
            is_r <= `GPP_RST_ZERO;
            ibe_r <= `GPP_RST_ZERO;
            iev_r <= `GPP_RST_ZERO;
            im_r <= `GPP_RST_ZERO;
            afsel_r <= DBG_RST;
            den_r <= DBG_RST;
            pur_r <= DBG_RST;
            pdr_r <= `GPP_RST_ZERO;
            dr2_r <= `GPP_RST_DRIVE2 & PIN_PRESENT;
            dr4_r <= `GPP_RST_ZERO;
            dr8_r <= `GPP_RST_ZERO;
            slr_r <= `GPP_RST_ZERO;
            odr_r <= `GPP_RST_ZERO;
        end else if (i_cfg_wr) begin
            case (i_cfg_sel)
                GPP_SEL_DIR: dir_r <= cfg_val;
                GPP_SEL_IS: is_r <= cfg_val;
                GPP_SEL_IBE: ibe_r <= cfg_val;
                GPP_SEL_IEV: iev_r <= cfg_val;
                GPP_SEL_IM: im_r <= cfg_val;
                GPP_SEL_AFSEL: begin
                    afsel_r <= (afsel_r & ~af_en) | (cfg_val & af_en);
                end
                GPP_SEL_DR2: begin
                    dr2_r <= dr2_r | cfg_val;
                    dr4_r <= dr4_r & ~cfg_val;
                    dr8_r <= dr8_r & ~cfg_val;
                end
                GPP_SEL_DR4: begin
                    dr4_r <= dr4_r | cfg_val;
                    dr2_r <= dr2_r & ~cfg_val;
                    dr8_r <= dr8_r & ~cfg_val;
                end
                GPP_SEL_DR8: begin
                    dr8_r <= dr8_r | cfg_val;
                    dr2_r <= dr2_r & ~cfg_val;
                    dr4_r <= dr4_r & ~cfg_val;
                end
                GPP_SEL_ODR: odr_r <= cfg_val;
                GPP_SEL_PUR: pur_r <= cfg_val;
                GPP_SEL_PDR: pdr_r <= cfg_val;
                GPP_SEL_DEN: den_r <= cfg_val;
                GPP_SEL_SLR: slr_r <= cfg_val & dr8_r;
                default: dir_r <= dir_r;
            endcase
        end
    end

    // Commit bits: only debug pins, only while unlocked
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cr_r <= ~DBG_PINS;
        end else if (i_cfg_wr && i_cfg_sel == GPP_SEL_CR && unlocked_r) begin
            cr_r <= (cr_r & ~DBG_PINS) | (i_cfg_wdata & DBG_PINS);
        end
    end

    // Lock opens on the key, closes on any other value
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            unlocked_r <= 1'b0;
        end else if (i_lock_wr) begin
            unlocked_r <= (i_lock_wdata == `GPP_LOCK_KEY);
        end
    end

    // ****************************************
    // Data register
    // ****************************************
    // Address bits act as a per-bit write mask
    assign data_wm = i_data_wr ? (i_data_addr & PIN_PRESENT) : '0;
    // Outputs take writes, inputs track the pin
    assign data_nxt = (dir_r & ((data_r & ~data_wm) | (i_data_wdata & data_wm)))
        | (~dir_r & pin_in_en);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            data_r <= `GPP_RST_ZERO;
        end else begin
            data_r <= data_nxt & PIN_PRESENT;
        end
    end

    // Masked read, answered one cycle later
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdata_r <= `GPP_RST_ZERO;
        end else if (i_data_rd) begin
            rdata_r <= data_r & i_data_addr & PIN_PRESENT;
        end else begin
            rdata_r <= `GPP_RST_ZERO;
        end
    end

    // ****************************************
    // Pin drive and alternate function
    // ****************************************
    // Peripheral owns the pin when selected
    assign drv_val = (afsel_r & i_alt_out) | (~afsel_r & data_r);
    assign drv_en = (afsel_r & i_alt_oe) | (~afsel_r & dir_r);
    // Open drain drives low only
    assign o_pin_out = drv_val & ~odr_r & PIN_PRESENT;
    assign o_pin_oe = drv_en & (~odr_r | ~drv_val) & PIN_PRESENT;
    assign o_alt_in = pin_in_en & afsel_r;

    // ****************************************
    // Interrupt detection
    // ****************************************
    for (genvar g = 0; g < `GPP_WIDTH; g++) begin : g_irq
        gpp_irq_pin u_irq (
            .i_sys_clk(i_sys_clk),
            .i_rst(i_rst),
            .i_level(pin_in_en[g]),
            .i_sense(is_r[g]),
            .i_both(ibe_r[g]),
            .i_polarity(iev_r[g]),
            .i_clear(i_irq_clear_wr & i_irq_clear_data[g]),
            .o_raw(raw[g])
        );
    end

    // Mask gates raw status onto one port line
    assign masked = raw & im_r & PIN_PRESENT;
    assign o_irq = |masked;

    // Converter trigger on a fresh unmasked pin four event, on port B only
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            raw_trig_d_r <= 1'b0;
            trig_r <= 1'b0;
        end else begin
            raw_trig_d_r <= raw[`GPP_TRIG_PIN];
            trig_r <= IS_PORT_B & masked[`GPP_TRIG_PIN]
                & ~raw_trig_d_r;
        end
    end

    // ****************************************
    // Identification bytes
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            id_r <= `GPP_RST_ZERO;
        end else if (i_id_sel < `GPP_ID_COUNT) begin
            id_r <= ID_TABLE[95 - 8 * i_id_sel -: 8];
        end else begin
            id_r <= `GPP_RST_ZERO;
        end
    end

    // ****************************************
    // Output assignments
    // ****************************************
    assign o_data_rdata = rdata_r;
    assign o_locked = ~unlocked_r;
    assign o_id_value = id_r;
    assign o_pin_direction_reg = dir_r;
    assign o_irq_sense_select = is_r;
    assign o_irq_both_edge_select = ibe_r;
    assign o_irq_event_polarity = iev_r;
    assign o_irq_mask_reg = im_r;
    assign o_alt_function_select = afsel_r;
    assign o_drive_two_ma_select = dr2_r;
    assign o_drive_four_ma_select = dr4_r;
    assign o_drive_eight_ma_select = dr8_r;
    assign o_slew_select = slr_r;
    assign o_open_drain_select = odr_r;
    assign o_pullup_select = pur_r;
    assign o_pulldown_select = pdr_r;
    assign o_digital_input_enable = den_r;
    assign o_commit_permit_reg = cr_r;
    assign o_pin_value_reg = data_r;
    assign o_irq_raw_status = raw;
    assign o_irq_masked_status = masked;
    assign o_conv_trigger = trig_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_pin_steady;
        (dir_r == `GPP_ALL_ZERO && den_r == PIN_PRESENT
            && $stable(i_pin_in))[*3];
    endsequence

    sequence s_clear_quiet;
        i_irq_clear_wr && i_irq_clear_data == `GPP_ALL_ONES
            && is_r == `GPP_ALL_ZERO && $stable(pin_in_en);
    endsequence

    AST_RESET_DEFAULTS: assert property ($past(i_rst) |-> afsel_r == DBG_RST
        && den_r == DBG_RST && pur_r == DBG_RST && pdr_r == `GPP_ALL_ZERO)
        else $error("Pin defaults wrong after reset");
    AST_IN_CAPTURE: assert property (s_pin_steady |->
        data_r == (i_pin_in & PIN_PRESENT))
        else $error("Input level not captured");
    AST_OUT_DRIVE: assert property (((~afsel_r & dir_r & ~odr_r)
        & (~o_pin_oe | (o_pin_out ^ data_r)) & PIN_PRESENT) == '0)
        else $error("Output pin not driven from data");
    AST_WR_KEEP: assert property (i_data_wr |=> ((data_r ^ $past(data_r))
        & ~$past(i_data_addr) & $past(dir_r)) == '0)
        else $error("Unmasked data bit changed");
    AST_RD_MASK: assert property (i_data_rd |=>
        (o_data_rdata & ~$past(i_data_addr)) == '0)
        else $error("Masked read bit not zero");
    AST_EDGE_HOLD: assert property (raw[0] && !is_r[0]
        && !i_irq_clear_wr && !$past(is_r[0]) |=> raw[0])
        else $error("Edge interrupt lost without clear");
    AST_LEVEL_SET: assert property (is_r[`GPP_TRIG_PIN]
        && pin_in_en[`GPP_TRIG_PIN] == iev_r[`GPP_TRIG_PIN]
        |=> raw[`GPP_TRIG_PIN])
        else $error("Level interrupt not raised");
    AST_CLEAR_DROP: assert property (s_clear_quiet |=> raw == '0 ##0 !o_irq)
        else $error("Clear did not drop interrupt");
    AST_AF_LOCKED: assert property (i_cfg_wr && i_cfg_sel == GPP_SEL_AFSEL
        && !unlocked_r |=> ((afsel_r ^ $past(afsel_r)) & DBG_PINS) == '0)
        else $error("Protected alternate bit changed while locked");
    AST_TRIGGER: assert property (IS_PORT_B && im_r[`GPP_TRIG_PIN]
        && $rose(raw[`GPP_TRIG_PIN]) |=> o_conv_trigger)
        else $error("Converter trigger missing");

endmodule

`default_nettype wire

// [gpp_pad_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Pad and external source model
// ****************************************
module gpp_pad_model
    import gpp_pkg::*;
(
    // Clock
    input wire logic i_sys_clk,
    // Port drive and pad settings
    input wire gpp_byte_t i_pin_out,
    input wire gpp_byte_t i_pin_oe,
    input wire gpp_byte_t i_pullup,
    input wire gpp_byte_t i_pulldown,
    // External source
    input wire gpp_byte_t i_ext_val,
    input wire gpp_byte_t i_ext_en,
    // Level seen at the pad
    output gpp_byte_t o_pad
);
    gpp_byte_t float_r = 8'h5A;

    // Floating pads wander every cycle so a stale level is never trusted
    always @(posedge i_sys_clk) begin
        float_r <= ~float_r;
    end

    // Port drive wins, then the external source, then the weak pulls
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (i_pin_oe[i]) begin
                o_pad[i] = i_pin_out[i];
            end else if (i_ext_en[i]) begin
                o_pad[i] = i_ext_val[i];
            end else if (i_pullup[i]) begin
                o_pad[i] = 1'b1;
            end else if (i_pulldown[i]) begin
                o_pad[i] = 1'b0;
            end else begin
                o_pad[i] = float_r[i];
            end
        end
    end
endmodule

`default_nettype wire

// [gpp_port_test.sv]
`timescale 1ns/10ps
`default_nettype none
`include "gpp_map.svh"

module gpp_port_test;
    import gpp_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    localparam gpp_byte_t PRES = 8'hBF;
    localparam logic [95:0] ID_TABLE = `GPP_ID_TABLE;
    localparam int AF = 0, DEN = 1, PU = 2, PD = 3, DR2 = 4, DR4 = 5;
    localparam int DR8 = 6, SLR = 7, CR = 8, VAL = 9, POUT = 10, POE = 11;
    localparam int RAW = 12, MIS = 13, MISC = 14, AIN = 15, IDV = 16;
    localparam int TRG = 17, DIR = 18, ODR = 19, IM = 20, ISS = 21;
    localparam int IBE = 22, IEV = 23;
    logic sys_clk = 1'b0;
    logic rst, data_wr, data_rd, cfg_wr, clr_wr, lock_wr, locked, irq, trig;
    logic [7:0] data_addr;
    logic [31:0] lock_wdata;
    logic [3:0] id_sel;
    gpp_cfg_sel_e cfg_sel;
    gpp_byte_t data_wdata, cfg_wdata, clr_data, alt_out, alt_oe, ext_val;
    gpp_byte_t ext_en, rdata, id_value, pin_out, pin_oe, alt_in, pad;
    gpp_byte_t af, den, pu, pd, dr2, dr4, dr8, slr, cr, val, raw, mis;
    gpp_byte_t dir, odr, im, sns, ibe, iev;
    gpp_byte_t trig_cnt = 8'h00;
    gpp_byte_t obs [24];
    gpp_byte_t exp_q [$];
    gpp_byte_t rd_q [$];
    int code_q [$];
    logic rd_pend = 1'b0;
    logic [31:0] seed = 32'h8545;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [2:0] mode_cfg [5] = '{3'b001, 3'b000, 3'b011, 3'b101, 3'b100};
    logic [2:0] mode_exp [5] = '{3'b110, 3'b010, 3'b110, 3'b100, 3'b011};

    always #2 sys_clk = ~sys_clk;

    // ****************************************
    // Design and pad model
    // ****************************************
    gpp_port #(.PORT_INDEX(`GPP_PORT_B), .PIN_PRESENT(PRES)) u_dut (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_data_wr(data_wr),
        .i_data_rd(data_rd), .i_data_addr(data_addr),
        .i_data_wdata(data_wdata), .o_data_rdata(rdata), .i_cfg_wr(cfg_wr),
        .i_cfg_sel(cfg_sel), .i_cfg_wdata(cfg_wdata),
        .i_irq_clear_wr(clr_wr), .i_irq_clear_data(clr_data),
        .i_lock_wr(lock_wr), .i_lock_wdata(lock_wdata), .o_locked(locked),
        .i_id_sel(id_sel), .o_id_value(id_value), .i_pin_in(pad),
        .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_alt_out(alt_out),
        .i_alt_oe(alt_oe), .o_alt_in(alt_in), .o_pin_direction_reg(dir),
        .o_irq_sense_select(sns), .o_irq_both_edge_select(ibe),
        .o_irq_event_polarity(iev), .o_irq_mask_reg(im),
        .o_alt_function_select(af), .o_drive_two_ma_select(dr2),
        .o_drive_four_ma_select(dr4), .o_drive_eight_ma_select(dr8),
        .o_slew_select(slr), .o_open_drain_select(odr), .o_pullup_select(pu),
        .o_pulldown_select(pd), .o_digital_input_enable(den),
        .o_commit_permit_reg(cr), .o_pin_value_reg(val),
        .o_irq_raw_status(raw), .o_irq_masked_status(mis), .o_irq(irq),
        .o_conv_trigger(trig));

    gpp_pad_model u_pads (.i_sys_clk(sys_clk), .i_pin_out(pin_out),
        .i_pin_oe(pin_oe), .i_pullup(pu), .i_pulldown(pd),
        .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pad(pad));

    // Observed values, indexed by check code
    always_comb begin
        obs = '{af, den, pu, pd, dr2, dr4, dr8, slr, cr, val, pin_out, pin_oe,
            raw, mis, {6'h00, locked, irq}, alt_in, id_value, trig_cnt, dir,
            odr, im, sns, ibe, iev};
    end

    // ****************************************
    // Monitor
    // ****************************************
    always @(posedge sys_clk) begin
        if (trig === 1'b1) begin
            trig_cnt <= trig_cnt + 8'h01;
        end
    end

    // Takes the oldest notes off the queues as results appear
    always @(posedge sys_clk) begin
        cycles++;
        if (rd_pend) begin
            chk(rdata, rd_q.pop_front(), -1);
        end
        rd_pend = data_rd;
        while (code_q.size() > 0) begin
            chk(obs[code_q[0]], exp_q.pop_front(), code_q[0]);
            code_q.delete(0);
        end
        if (cycles > 6000) begin
            errors++;
            $display("ERROR t=%0t run did not finish in time", $time);
            report_and_stop();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input gpp_byte_t got, input gpp_byte_t exp,
        input int code);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t code %0d got %h want %h", $time, code, got,
                exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic expect_v(input int code, input gpp_byte_t v);
        code_q.push_back(code);
        exp_q.push_back(v);
    endtask

    // Kind 0 data write, 1 config write, 2 interrupt clear, 3 lock key
    task automatic put(input int k, input logic [7:0] a,
        input logic [31:0] v);
        data_addr = a;
        data_wdata = v[7:0];
        cfg_wdata = v[7:0];
        clr_data = v[7:0];
        lock_wdata = v;
        {data_wr, cfg_wr, clr_wr, lock_wr} = {k == 0, k == 1, k == 2, k == 3};
        cyc(1);
        {data_wr, cfg_wr, clr_wr, lock_wr} = 4'h0;
        cyc(1);
    endtask

    task automatic cfgw(input gpp_cfg_sel_e s, input gpp_byte_t v);
        cfg_sel = s;
        put(1, 8'h00, {24'h0, v});
    endtask

    task automatic rd(input gpp_byte_t m, input gpp_byte_t e);
        data_addr = m;
        data_rd = 1'b1;
        rd_q.push_back(e);
        cyc(1);
        data_rd = 1'b0;
        cyc(1);
    endtask

    task automatic chk_reset();
        expect_v(AF, 8'h80);
        expect_v(DEN, 8'h80);
        expect_v(PU, 8'h80);
        expect_v(PD, 8'h00);
        expect_v(DIR, 8'h00);
        expect_v(POE, 8'h00);
        expect_v(DR2, PRES);
        expect_v(CR, 8'h7F);
        expect_v(MISC, 8'h02);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        gpp_byte_t d, m, e;
        logic [2:0] c, x;
        {rst, data_wr, data_rd, cfg_wr, clr_wr, lock_wr} = 6'h20;
        {data_addr, data_wdata, cfg_wdata, clr_data} = 32'h0;
        {lock_wdata, id_sel, alt_out, alt_oe, ext_val, ext_en} = 68'h0;
        cfg_sel = GPP_SEL_DIR;
        cyc(16);
        rst = 1'b0;
        cyc(1);
        chk_reset();
        // Protected bit refused while locked or not committed
        cfgw(GPP_SEL_AFSEL, 8'h00);
        expect_v(AF, 8'h80);
        put(3, 8'h00, `GPP_LOCK_KEY);
        expect_v(MISC, 8'h00);
        cfgw(GPP_SEL_AFSEL, 8'h01);
        expect_v(AF, 8'h81);
        cfgw(GPP_SEL_CR, 8'hFF);
        cfgw(GPP_SEL_AFSEL, 8'h00);
        expect_v(AF, 8'h00);
        put(3, 8'h00, 32'h0);
        // Output data with address masking, random values
        cfgw(GPP_SEL_DEN, 8'hFF);
        cfgw(GPP_SEL_DIR, 8'hFF);
        expect_v(DIR, PRES);
        expect_v(POE, PRES);
        // Start from a known zero, the inputs left floating levels behind
        put(0, 8'hFF, 32'h0);
        e = 8'h00;
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'hEB : gpp_byte_t'(rnd());
            m = (i == 0) ? 8'h26 : gpp_byte_t'(rnd());
            put(0, m, {24'h0, d});
            e = (e & ~m) | (d & m);
            expect_v(VAL, e & PRES);
            expect_v(POUT, e & PRES);
            m = gpp_byte_t'(rnd());
            rd(m, e & m & PRES);
        end
        // Drive strength, slew, open drain and pull-up
        cfgw(GPP_SEL_DR8, 8'h0F);
        expect_v(DR8, 8'h0F);
        expect_v(DR2, 8'hB0);
        expect_v(DR4, 8'h00);
        cfgw(GPP_SEL_SLR, 8'hFF);
        expect_v(SLR, 8'h0F);
        put(0, 8'hFF, 32'h0F);
        cfgw(GPP_SEL_ODR, 8'hFF);
        expect_v(ODR, PRES);
        expect_v(POE, 8'hB0);
        expect_v(POUT, 8'h00);
        cfgw(GPP_SEL_ODR, 8'h00);
        cfgw(GPP_SEL_PUR, 8'h01);
        expect_v(PU, 8'h01);
        // Input capture through the synchroniser
        ext_val = 8'h3C;
        ext_en = 8'hFF;
        cfgw(GPP_SEL_DIR, 8'h00);
        ext_val = 8'h82;
        cyc(2);
        expect_v(VAL, 8'h3C);
        cyc(1);
        expect_v(VAL, 8'h82);
        // Alternate function takes pin 0
        {alt_out, alt_oe} = 16'h0101;
        cfgw(GPP_SEL_AFSEL, 8'h01);
        cyc(3);
        expect_v(POE, 8'h01);
        expect_v(AIN, 8'h01);
        cfgw(GPP_SEL_AFSEL, 8'h00);
        {alt_out, alt_oe} = 16'h0000;
        ext_val = 8'h00;
        // Pin 4 interrupt in each mode, masked while it is set up
        for (int k = 0; k < 5; k++) begin
            c = mode_cfg[k];
            x = mode_exp[k];
            cfgw(GPP_SEL_IM, 8'h00);
            cfgw(GPP_SEL_IS, {3'h0, c[2], 4'h0});
            cfgw(GPP_SEL_IBE, {3'h0, c[1], 4'h0});
            cfgw(GPP_SEL_IEV, {3'h0, c[0], 4'h0});
            expect_v(ISS, {3'h0, c[2], 4'h0});
            expect_v(IBE, {3'h0, c[1], 4'h0});
            expect_v(IEV, {3'h0, c[0], 4'h0});
            put(2, 8'h00, 32'hFF);
            cfgw(GPP_SEL_IM, 8'h10);
            expect_v(IM, 8'h10);
            d = trig_cnt;
            ext_val = 8'h10;
            cyc(5);
            expect_v(RAW, {3'h0, x[2], 4'h0});
            expect_v(MISC, {6'h00, 1'b1, x[2]});
            if (k < 4) begin
                expect_v(TRG, d + {7'h00, x[2]});
            end
            ext_val = 8'h00;
            cyc(5);
            expect_v(RAW, {3'h0, x[1], 4'h0});
            put(2, 8'h00, 32'h00);
            expect_v(RAW, {3'h0, x[1], 4'h0});
            put(2, 8'h00, 32'hFF);
            expect_v(RAW, {3'h0, x[0], 4'h0});
            expect_v(MISC, {6'h00, 1'b1, x[0]});
            cfgw(GPP_SEL_IM, 8'h00);
            expect_v(MIS, 8'h00);
            expect_v(RAW, {3'h0, x[0], 4'h0});
        end
        // Identification bytes
        for (int i = 0; i < 13; i++) begin
            id_sel = i[3:0];
            cyc(1);
            expect_v(IDV, (i < 12) ? ID_TABLE[95 - 8 * i -: 8] : 8'h00);
        end
        // Reset in mid-run restores the defaults
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(1);
        chk_reset();
        cyc(2);
        report_and_stop();
    end
endmodule

`default_nettype wire
